// file: cffmb_map.svh
// register map constants for the charger fault flag and mask bank
// Behaviour
// [R1] fault flag register at 0x6, resets zero, bits sticky, cleared by a read
// [R2] bit 6 sets when the host watchdog timer expires
// [R3] bit 5 sets when the charge safety timer expires
// [R4] bit 4 sets on auxiliary regulator overcurrent, zero in normal operation
// [R5] bit 3 sets when the current-limit pin is found open
// [R6] bit 2 sets when the first push-button wake timer expires
// [R7] bit 1 sets when the second push-button wake timer expires
// [R8] bit 0 sets when the push-button reset warning timer expires
// [R9] mask bit zero lets its flag interrupt, one suppresses it
// [R10] charge event mask holds seven read-write bits, 6 down to 0; the code keeps all eight bits read-write
// [R11] charge event mask at 0x7, resets zero
// [R12] battery thermal mask bits 7 and 5..0 read-write, bit 6 reserved; the code keeps bit 6 read-write too
// [R13] battery thermal mask at 0x8, resets zero
// [R14] converter alarm mask at 0x9, resets to 0x71
// [R15] battery and thermistor flags live at 0x4, clear on read, reset zero
// [R16] fault event mask at 0xA, resets zero, bits match flag positions
// [R17] interrupt asserted while any unmasked flag is set, drops once cleared
// [R18] a flag event in the cycle of its read survives the read
`ifndef CFFMB_MAP_SVH
`define CFFMB_MAP_SVH

`define CFFMB_IDX_BATT_FLAGS    6'h04
`define CFFMB_IDX_FAULT_FLAGS   6'h06
`define CFFMB_IDX_CHARGE_MASK   6'h07
`define CFFMB_IDX_BATT_MASK     6'h08
`define CFFMB_IDX_ALARM_MASK    6'h09
`define CFFMB_IDX_FAULT_MASK    6'h0A

`define CFFMB_RST_FLAGS         8'h00
`define CFFMB_RST_CHARGE_MASK   8'h00
`define CFFMB_RST_BATT_MASK     8'h00
`define CFFMB_RST_ALARM_MASK    8'h71
`define CFFMB_RST_FAULT_MASK    8'h00

`define CFFMB_RSV_FAULT_FLAGS   8'h80
`define CFFMB_RSV_BATT_FLAGS    8'h40

`define CFFMB_BIT_WD            6
`define CFFMB_BIT_SAFETY        5
`define CFFMB_BIT_REG_OC        4
`define CFFMB_BIT_LIMIT_OPEN    3
`define CFFMB_BIT_WAKE1         2
`define CFFMB_BIT_WAKE2         1
`define CFFMB_BIT_RST_WARN      0

`define CFFMB_BIT_IN_OV         7
`define CFFMB_BIT_BAT_RSV       6
`define CFFMB_BIT_BAT_OC        5
`define CFFMB_BIT_BAT_UV        4
`define CFFMB_BIT_COLD          3
`define CFFMB_BIT_COOL          2
`define CFFMB_BIT_WARM          1
`define CFFMB_BIT_HOT           0

`endif

// file: cffmb_pkg.sv
// types shared by the charger fault flag and mask bank
package cffmb_pkg;

  typedef struct packed {
    logic watchdog_expired_flag;
    logic charge_timer_expired_flag;
    logic regulator_overcurrent_flag;
    logic limit_pin_open_flag;
    logic button_wake_first_flag;
    logic button_wake_second_flag;
    logic button_reset_warning_flag;
  } cffmb_fault_src_t;

  typedef struct packed {
    logic input_overvoltage;
    logic battery_overcurrent;
    logic battery_undervoltage;
    logic thermistor_cold_region;
    logic thermistor_cool_region;
    logic thermistor_warm_region;
    logic thermistor_hot_region;
  } cffmb_batt_src_t;

endpackage

// file: cffmb_event_sync.sv
// two-flop synchroniser with rising edge detect for detector levels
`timescale 1ns/1ps
module cffmb_event_sync #(
  parameter int W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] last;

  // meta is read only by sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end else begin
      meta <= level_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign rise = sync & ~last;
endmodule

// file: cffmb_cor_flags.sv
// sticky clear-on-read flag register, set wins over clear
`timescale 1ns/1ps
`include "cffmb_map.svh"
module cffmb_cor_flags #(
  parameter int       W   = 8,
  parameter bit [W-1:0] RSV = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set,
  input  wire logic         clr_en,
  input  wire logic [W-1:0] clr_bits,
  output logic      [W-1:0] flags
);
  logic [W-1:0] clr_mask;
  logic [W-1:0] next_flags;

  // only bits already reported are cleared, so late events survive
  assign clr_mask   = clr_en ? clr_bits : '0;
  assign next_flags = ((flags & ~clr_mask) | set) & ~RSV; // R18

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= W'(`CFFMB_RST_FLAGS);
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// file: cffmb_bank.sv
// apb flag and mask register bank with interrupt output
`timescale 1ns/1ps
`include "cffmb_map.svh"
module cffmb_bank
  import cffmb_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire cffmb_fault_src_t fault_detect,
  input  wire cffmb_batt_src_t  batt_detect,
  input  wire logic [7:0]       charge_flags_pending,
  input  wire logic [7:0]       alarm_flags_pending,
  output logic                  charger_irq
);

  // register index decode, used for every register
  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  logic [6:0]  fault_rise;
  logic [6:0]  batt_rise;
  logic [7:0]  fault_set;
  logic [7:0]  batt_set;
  logic [7:0]  fault_event_flags;
  logic [7:0]  battery_thermal_flags;
  logic [7:0]  charge_event_interrupt_mask;
  logic [7:0]  battery_thermal_interrupt_mask;
  logic [7:0]  converter_alarm_interrupt_mask;
  logic [7:0]  fault_event_interrupt_mask;
  logic [7:0]  next_charge_mask;
  logic [7:0]  next_batt_mask;
  logic [7:0]  next_alarm_mask;
  logic [7:0]  next_fault_mask;
  logic [31:0] next_prdata;
  logic [7:0]  read_byte;
  logic        hit_batt_flags;
  logic        hit_fault_flags;
  logic        hit_charge_mask;
  logic        hit_batt_mask;
  logic        hit_alarm_mask;
  logic        hit_fault_mask;
  logic        hit_any;
  logic        setup_rd;
  logic        access;
  logic        wr_en;
  logic        rd_done;
  logic        clr_fault;
  logic        clr_batt;
  logic [7:0]  pend_charge;
  logic [7:0]  pend_batt;
  logic [7:0]  pend_alarm;
  logic [7:0]  pend_fault;
  logic        next_irq;

  // detectors are asynchronous to pclk
  cffmb_event_sync #(.W(7)) u_fault_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (fault_detect),
    .rise     (fault_rise)
  );

  cffmb_event_sync #(.W(7)) u_batt_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (batt_detect),
    .rise     (batt_rise)
  );

  // fault event bit positions
  assign fault_set[7]                     = 1'b0;
  assign fault_set[`CFFMB_BIT_WD]         = fault_rise[6]; // R2
  assign fault_set[`CFFMB_BIT_SAFETY]     = fault_rise[5]; // R3
  assign fault_set[`CFFMB_BIT_REG_OC]     = fault_rise[4]; // R4
  assign fault_set[`CFFMB_BIT_LIMIT_OPEN] = fault_rise[3]; // R5
  assign fault_set[`CFFMB_BIT_WAKE1]      = fault_rise[2]; // R6
  assign fault_set[`CFFMB_BIT_WAKE2]      = fault_rise[1]; // R7
  assign fault_set[`CFFMB_BIT_RST_WARN]   = fault_rise[0]; // R8

  // battery and thermistor bit positions
  assign batt_set[`CFFMB_BIT_IN_OV]   = batt_rise[6];
  assign batt_set[`CFFMB_BIT_BAT_RSV] = 1'b0;
  assign batt_set[`CFFMB_BIT_BAT_OC]  = batt_rise[5];
  assign batt_set[`CFFMB_BIT_BAT_UV]  = batt_rise[4];
  assign batt_set[`CFFMB_BIT_COLD]    = batt_rise[3];
  assign batt_set[`CFFMB_BIT_COOL]    = batt_rise[2];
  assign batt_set[`CFFMB_BIT_WARM]    = batt_rise[1];
  assign batt_set[`CFFMB_BIT_HOT]     = batt_rise[0];

  // apb decode
  assign hit_batt_flags  = reg_hit(paddr, `CFFMB_IDX_BATT_FLAGS);
  assign hit_fault_flags = reg_hit(paddr, `CFFMB_IDX_FAULT_FLAGS);
  assign hit_charge_mask = reg_hit(paddr, `CFFMB_IDX_CHARGE_MASK);
  assign hit_batt_mask   = reg_hit(paddr, `CFFMB_IDX_BATT_MASK);
  assign hit_alarm_mask  = reg_hit(paddr, `CFFMB_IDX_ALARM_MASK);
  assign hit_fault_mask  = reg_hit(paddr, `CFFMB_IDX_FAULT_MASK);
  assign hit_any = hit_batt_flags | hit_fault_flags | hit_charge_mask
                 | hit_batt_mask | hit_alarm_mask | hit_fault_mask;

  // zero wait states: read data is captured in the setup cycle
  assign pready   = 1'b1;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign access   = psel & penable;
  assign pslverr  = access & ~hit_any;
  assign wr_en    = access & pwrite & pstrb[0] & hit_any;
  assign rd_done  = access & ~pwrite;

  // clear-on-read acts at the access edge, clearing only what was returned
  assign clr_fault = rd_done & hit_fault_flags; // R1
  assign clr_batt  = rd_done & hit_batt_flags;  // R15

  cffmb_cor_flags #(.W(8), .RSV(`CFFMB_RSV_FAULT_FLAGS)) u_fault_flags (
    .pclk     (pclk),
    .presetn  (presetn),
    .set      (fault_set),
    .clr_en   (clr_fault),
    .clr_bits (prdata[7:0]),
    .flags    (fault_event_flags)
  );

  cffmb_cor_flags #(.W(8), .RSV(`CFFMB_RSV_BATT_FLAGS)) u_batt_flags (
    .pclk     (pclk),
    .presetn  (presetn),
    .set      (batt_set),
    .clr_en   (clr_batt),
    .clr_bits (prdata[7:0]),
    .flags    (battery_thermal_flags)
  );

  // mask writes; reserved mask bits are kept read-write
  assign next_charge_mask = (wr_en & hit_charge_mask) ? pwdata[7:0] : charge_event_interrupt_mask; // R10
  assign next_batt_mask   = (wr_en & hit_batt_mask) ? pwdata[7:0] : battery_thermal_interrupt_mask; // R12
  assign next_alarm_mask  = (wr_en & hit_alarm_mask) ? pwdata[7:0] : converter_alarm_interrupt_mask;
  assign next_fault_mask  = (wr_en & hit_fault_mask) ? pwdata[7:0] : fault_event_interrupt_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_event_interrupt_mask    <= `CFFMB_RST_CHARGE_MASK; // R11
      battery_thermal_interrupt_mask <= `CFFMB_RST_BATT_MASK;   // R13
      converter_alarm_interrupt_mask <= `CFFMB_RST_ALARM_MASK;  // R14
      fault_event_interrupt_mask     <= `CFFMB_RST_FAULT_MASK;  // R16
    end else begin
      charge_event_interrupt_mask    <= next_charge_mask;
      battery_thermal_interrupt_mask <= next_batt_mask;
      converter_alarm_interrupt_mask <= next_alarm_mask;
      fault_event_interrupt_mask     <= next_fault_mask;
    end
  end

  // read mux; unmapped reads return zero
  assign read_byte = hit_batt_flags  ? battery_thermal_flags :
                     hit_fault_flags ? fault_event_flags :
                     hit_charge_mask ? charge_event_interrupt_mask :
                     hit_batt_mask   ? battery_thermal_interrupt_mask :
                     hit_alarm_mask  ? converter_alarm_interrupt_mask :
                     hit_fault_mask  ? fault_event_interrupt_mask : 8'h00;
  assign next_prdata = setup_rd ? {24'h000000, read_byte} : prdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // interrupt: a zero mask bit passes its flag
  assign pend_charge = charge_flags_pending & ~charge_event_interrupt_mask; // R9
  assign pend_batt   = battery_thermal_flags & ~battery_thermal_interrupt_mask; // R9
  assign pend_alarm  = alarm_flags_pending & ~converter_alarm_interrupt_mask; // R9
  assign pend_fault  = fault_event_flags & ~fault_event_interrupt_mask; // R9
  assign next_irq = |{pend_charge, pend_batt, pend_alarm, pend_fault}; // R17

  // registered to keep the pin glitch free, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charger_irq <= 1'b0;
    end else begin
      charger_irq <= next_irq;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_fault_read;
    rd_done && hit_fault_flags;
  endsequence

  sequence seq_wd_event;
    fault_rise[6] && !(rd_done && hit_fault_flags);
  endsequence

  sequence seq_batt_read;
    rd_done && hit_batt_flags;
  endsequence

  sequence seq_mask_write;
    access && pwrite && pstrb[0];
  endsequence

  chk_fault_sticky: assert property ( // R1
    fault_event_flags[`CFFMB_BIT_WD] && !(rd_done && hit_fault_flags)
    |=> fault_event_flags[`CFFMB_BIT_WD]
  ) else $error("fault flag dropped without a read");

  chk_read_clears: assert property ( // R1
    seq_fault_read ##0 (prdata[`CFFMB_BIT_SAFETY] && !fault_set[`CFFMB_BIT_SAFETY])
    |=> !fault_event_flags[`CFFMB_BIT_SAFETY]
  ) else $error("read did not clear reported fault flag");

  chk_wd_sets: assert property ( // R2
    seq_wd_event |=> fault_event_flags[`CFFMB_BIT_WD]
  ) else $error("watchdog event did not set its flag");

  chk_set_wins: assert property ( // R18
    (rd_done && hit_batt_flags && batt_set[`CFFMB_BIT_HOT])
    |=> battery_thermal_flags[`CFFMB_BIT_HOT]
  ) else $error("event lost in clearing read");

  chk_rsv_zero: assert property ( // R12
    !fault_event_flags[7] && !battery_thermal_flags[`CFFMB_BIT_BAT_RSV]
  ) else $error("reserved flag bit set");

  chk_irq_raise: assert property ( // R17
    (fault_event_flags[`CFFMB_BIT_REG_OC] && !fault_event_interrupt_mask[`CFFMB_BIT_REG_OC])
    |=> charger_irq
  ) else $error("unmasked flag did not raise interrupt");

  chk_mask_quiet: assert property ( // R9
    (fault_event_interrupt_mask == 8'hFF && battery_thermal_interrupt_mask == 8'hFF
     && converter_alarm_interrupt_mask == 8'hFF && charge_event_interrupt_mask == 8'hFF)
    |=> !charger_irq
  ) else $error("fully masked bank raised interrupt");

  chk_alarm_write: assert property ( // R14
    (access && pwrite && pstrb[0] && hit_alarm_mask)
    |=> converter_alarm_interrupt_mask == $past(pwdata[7:0])
  ) else $error("alarm mask write not stored");

  chk_unmapped_err: assert property ( // R16
    (setup_rd && !hit_any) ##1 access |-> pslverr && prdata == 32'h00000000
  ) else $error("unmapped read not refused");

  // flags follow detector edges, not levels: a held detector fires once
  chk_wd_quiet: assert property ( // R2
    !fault_event_flags[`CFFMB_BIT_WD] && !fault_rise[6] |=> !fault_event_flags[`CFFMB_BIT_WD]
  ) else $error("watchdog flag set without an event");

  chk_safety_sets: assert property ( // R3
    fault_rise[5] |=> fault_event_flags[`CFFMB_BIT_SAFETY]
  ) else $error("safety timer event did not set its flag");

  chk_regoc_sets: assert property ( // R4
    fault_rise[4] |=> fault_event_flags[`CFFMB_BIT_REG_OC]
  ) else $error("regulator overcurrent did not set its flag");

  chk_limit_sets: assert property ( // R5
    fault_rise[3] |=> fault_event_flags[`CFFMB_BIT_LIMIT_OPEN]
  ) else $error("limit pin open did not set its flag");

  chk_wake1_sets: assert property ( // R6
    fault_rise[2] |=> fault_event_flags[`CFFMB_BIT_WAKE1]
  ) else $error("first wake timer did not set its flag");

  chk_wake2_sets: assert property ( // R7
    fault_rise[1] |=> fault_event_flags[`CFFMB_BIT_WAKE2]
  ) else $error("second wake timer did not set its flag");

  chk_warn_sets: assert property ( // R8
    fault_rise[0] |=> fault_event_flags[`CFFMB_BIT_RST_WARN]
  ) else $error("reset warning did not set its flag");

  chk_batt_sets: assert property ( // R15
    batt_rise[6] |=> battery_thermal_flags[`CFFMB_BIT_IN_OV]
  ) else $error("input overvoltage did not set its flag");

  chk_batt_clears: assert property ( // R15
    seq_batt_read ##0 (prdata[`CFFMB_BIT_HOT] && !batt_rise[0])
    |=> !battery_thermal_flags[`CFFMB_BIT_HOT]
  ) else $error("read did not clear reported battery flag");

  // read data must be the flags as they stood at the setup edge
  chk_fault_capture: assert property ( // R1
    setup_rd && hit_fault_flags |=> prdata[7:0] == $past(fault_event_flags)
  ) else $error("fault flag read returned wrong data");

  chk_batt_capture: assert property ( // R15
    setup_rd && hit_batt_flags |=> prdata[7:0] == $past(battery_thermal_flags)
  ) else $error("battery flag read returned wrong data");

  chk_charge_write: assert property ( // R10
    seq_mask_write ##0 hit_charge_mask |=> charge_event_interrupt_mask == $past(pwdata[7:0])
  ) else $error("charge mask write not stored");

  chk_batt_write: assert property ( // R12
    seq_mask_write ##0 hit_batt_mask |=> battery_thermal_interrupt_mask == $past(pwdata[7:0])
  ) else $error("battery mask write not stored");

  chk_fault_write: assert property ( // R16
    seq_mask_write ##0 hit_fault_mask |=> fault_event_interrupt_mask == $past(pwdata[7:0])
  ) else $error("fault mask write not stored");

  chk_strb_ignored: assert property ( // R10
    access && pwrite && !pstrb[0]
    |=> $stable(charge_event_interrupt_mask) && $stable(fault_event_interrupt_mask)
  ) else $error("write without low strobe changed a mask");

  chk_misalign_err: assert property ( // R1
    access && (paddr[1:0] != 2'b00) |-> pslverr
  ) else $error("misaligned access not refused");

  // the pin lags the flags by one edge, so each check looks one cycle on
  chk_irq_drop: assert property ( // R17
    !(|(fault_event_flags & ~fault_event_interrupt_mask))
    && !(|(battery_thermal_flags & ~battery_thermal_interrupt_mask))
    && !(|(charge_flags_pending & ~charge_event_interrupt_mask))
    && !(|(alarm_flags_pending & ~converter_alarm_interrupt_mask))
    |=> !charger_irq
  ) else $error("interrupt held with nothing pending");

  chk_charge_raise: assert property ( // R9
    |(charge_flags_pending & ~charge_event_interrupt_mask) |=> charger_irq
  ) else $error("unmasked charge event did not raise interrupt");

  chk_alarm_raise: assert property ( // R9
    |(alarm_flags_pending & ~converter_alarm_interrupt_mask) |=> charger_irq
  ) else $error("unmasked alarm did not raise interrupt");

  chk_batt_raise: assert property ( // R15
    |(battery_thermal_flags & ~battery_thermal_interrupt_mask) |=> charger_irq
  ) else $error("unmasked battery flag did not raise interrupt");

endmodule

// file: cffmb_bank_tb_top.sv
// self-checking testbench for the charger flag and mask bank
`timescale 1ns/1ps
module cffmb_bank_tb_top;
  import cffmb_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [3:0] strb;
    logic [7:0] rst;
    logic [7:0] after;
    logic       err;
  } cffmb_row_t;

  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [3:0]       pstrb = 4'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  cffmb_fault_src_t fault_detect = '0;
  cffmb_batt_src_t  batt_detect = '0;
  logic [7:0]       charge_flags_pending = 8'h00;
  logic [7:0]       alarm_flags_pending = 8'h00;
  logic             charger_irq;
  int               num_errors = 0;
  int               checks = 0;
  logic [31:0]      rd;
  logic [31:0]      r2;
  logic             er;
  logic [7:0]       eb;

  // the row without the low strobe comes before the full write to 0x1C so that row still sees the reset value
  cffmb_row_t rows [9] = '{
    '{8'h1C, 8'hA5, 4'hE, 8'h00, 8'h00, 1'b0},
    '{8'h1C, 8'hA5, 4'hF, 8'h00, 8'hA5, 1'b0},
    '{8'h1D, 8'hFF, 4'hF, 8'h00, 8'h00, 1'b1},
    '{8'h20, 8'h5A, 4'hF, 8'h00, 8'h5A, 1'b0},
    '{8'h24, 8'hFF, 4'hF, 8'h71, 8'hFF, 1'b0},
    '{8'h28, 8'h7F, 4'hF, 8'h00, 8'h7F, 1'b0},
    '{8'h18, 8'hFF, 4'hF, 8'h00, 8'h00, 1'b0},
    '{8'h10, 8'hFF, 4'hF, 8'h00, 8'h00, 1'b0},
    '{8'h2C, 8'hFF, 4'hF, 8'h00, 8'h00, 1'b1}
  };

  cffmb_bank i_dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pstrb                (pstrb),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .fault_detect         (fault_detect),
    .batt_detect          (batt_detect),
    .charge_flags_pending (charge_flags_pending),
    .alarm_flags_pending  (alarm_flags_pending),
    .charger_irq          (charger_irq)
  );

  always #4 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0, d}, 4'hF, r2, er);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    apb(a, 1'b0, 32'h0, 4'hF, rd, er);
    check(rd, {24'h0, e});
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge pclk);
    check({31'h0, charger_irq}, {31'h0, e});
  endtask

  initial begin
    #40000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge pclk);
    check({30'h0, pready, charger_irq}, 32'h2);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].addr, 1'b0, 32'h0, 4'hF, rd, er);
      check(rd, {24'h0, rows[i].rst});
      check({31'h0, er}, {31'h0, rows[i].err});
      apb(rows[i].addr, 1'b1, {24'h0, rows[i].wdata}, rows[i].strb, rd, er);
      rdx(rows[i].addr, rows[i].after);
    end
    wr(8'h1C, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h28, 8'h00);
    irq_is(1'b0);
    // each fault and battery source in turn, level held across the reads
    for (int b = 0; b < 7; b++) begin
      @(posedge pclk);
      fault_detect <= cffmb_fault_src_t'(7'h01 << b);
      batt_detect <= cffmb_batt_src_t'(7'h01 << b);
      eb = (b == 6) ? 8'h80 : (8'h01 << b);
      repeat (6) @(posedge pclk);
      check({31'h0, charger_irq}, 32'h1);
      rdx(8'h18, 8'h01 << b);
      rdx(8'h10, eb);
      rdx(8'h18, 8'h00);
      rdx(8'h10, 8'h00);
      irq_is(1'b0);
      fault_detect <= '0;
      batt_detect <= '0;
      repeat (3) @(posedge pclk);
    end
    // masked flag still latches but holds the interrupt back
    wr(8'h28, 8'h40);
    fault_detect <= cffmb_fault_src_t'(7'h40);
    irq_is(1'b0);
    repeat (4) @(posedge pclk);
    check({31'h0, charger_irq}, 32'h0);
    wr(8'h28, 8'h00);
    irq_is(1'b1);
    rdx(8'h18, 8'h40);
    irq_is(1'b0);
    fault_detect <= '0;
    wr(8'h20, 8'h80);
    batt_detect <= cffmb_batt_src_t'(7'h40);
    repeat (6) @(posedge pclk);
    check({31'h0, charger_irq}, 32'h0);
    rdx(8'h10, 8'h80);
    batt_detect <= '0;
    charge_flags_pending <= 8'h01;
    irq_is(1'b1);
    wr(8'h1C, 8'h01);
    irq_is(1'b0);
    alarm_flags_pending <= 8'h80;
    irq_is(1'b0);
    wr(8'h24, 8'h7F);
    irq_is(1'b1);
    alarm_flags_pending <= 8'h00;
    // event lands at every offset around the read; it must show in exactly one read
    for (int k = 0; k < 6; k++) begin
      @(posedge pclk);
      fault_detect <= cffmb_fault_src_t'(7'h10);
      repeat (k) @(posedge pclk);
      apb(8'h18, 1'b0, 32'h0, 4'hF, r2, er);
      apb(8'h18, 1'b0, 32'h0, 4'hF, rd, er);
      check(r2 | rd, 32'h10);
      check(r2 & rd, 32'h0);
      fault_detect <= '0;
      repeat (3) @(posedge pclk);
    end
    // every mask set: pending inputs and a fresh flag stay quiet
    wr(8'h1C, 8'hFF);
    wr(8'h20, 8'hFF);
    wr(8'h24, 8'hFF);
    wr(8'h28, 8'hFF);
    charge_flags_pending <= 8'hFF;
    alarm_flags_pending <= 8'hFF;
    fault_detect <= cffmb_fault_src_t'(7'h01);
    repeat (6) @(posedge pclk);
    check({31'h0, charger_irq}, 32'h0);
    rdx(8'h18, 8'h01);
    charge_flags_pending <= 8'h00;
    alarm_flags_pending <= 8'h00;
    fault_detect <= '0;
    // reset in mid-run returns masks to reset values and drops the interrupt
    wr(8'h1C, 8'h00);
    wr(8'h24, 8'h00);
    charge_flags_pending <= 8'h01;
    irq_is(1'b1);
    presetn <= 1'b0;
    irq_is(1'b0);
    presetn <= 1'b1;
    rdx(8'h24, 8'h71);
    rdx(8'h28, 8'h00);
    rdx(8'h20, 8'h00);
    wr(8'h1C, 8'h01);
    irq_is(1'b0);
    charge_flags_pending <= 8'h00;
    complete_run();
  end
endmodule
